/* File: hdl/multi_purpose_pin_port.sv */
// Overview of operation
// - eight bidirectional pins, each independently input or output.
// - host writes mode word to data register then issues pin-setup command.
// - two mode bits per pin; pin n uses bits 2n+1 and 2n.
// - mode pair 00 puts the pin in input state.
// - mode pair 01 drives the pin as general output.
// - mode pair 10 drives the pin with drive status.
// - mode pair 11 drives synchronous pulse or compare result by pin index.
// - in mode 11, pins 0 to 3 carry synchronous pulses.
// - in mode 11, pins 4 to 7 carry compare results 0 to 3.
// - pin levels always readable in low byte of pin-level register.
// - general output pins follow output word low byte bits.
// - input pin edges serve as synchronous-action triggers.
// - pins 4 and 5 inputs can start driving by level or edge.
// - with 8-bit bus, upper data lines are readable as inputs.
// - a disabled dedicated input may be read as general input.
// - upper data line levels appear in upper byte of pin-level register.
//
// file: top of the multi-purpose pin port with its apb register slave
// assumes pins and upper data lines are asynchronous; sources are on clock
//
// Design decisions made here: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
`include "mpp_cfg.svh"
module multi_purpose_pin_port
  import mpp_pkg::*;
#(
  parameter int PINS       = 8,
  parameter int UPPER      = 8,
  parameter int DEDICATED  = 9
) (
  // clock and reset
  input  wire logic                  clock,
  input  wire logic                  rst,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // pins
  input  wire logic [PINS-1:0]       pin_in,
  output logic      [PINS-1:0]       pin_out,
  output logic      [PINS-1:0]       pin_oe,
  // upper data lines used as inputs in 8-bit bus mode
  input  wire logic [UPPER-1:0]      upper_bus_line_levels,
  // dedicated inputs and their function enables
  input  wire logic [DEDICATED-1:0]  dedicated_in,
  input  wire logic [DEDICATED-1:0]  dedicated_fn_en,
  // sources from the rest of the device
  input  wire pin_sources_t          sources,
  // events toward synchronous action and external drive start
  output logic      [PINS-1:0]       sync_rise_r,
  output logic      [PINS-1:0]       sync_fall_r,
  output logic      [1:0]            ext_start_level_r,
  output logic      [1:0]            ext_start_edge_r,
  output logic      [DEDICATED-1:0]  dedicated_level_r
);
  // ------------------------------------------------------------
  // register state
  // ------------------------------------------------------------
  logic [15:0]          data_write_low_word_r;
  logic [15:0]          pin_mode_word_r;
  logic [15:0]          output_word_register_r;
  logic                 bus8_mode_r;
  logic [PINS-1:0]      pin_meta_r;
  logic [PINS-1:0]      pin_sync_r;
  logic [PINS-1:0]      pin_prev_r;
  logic [UPPER-1:0]     upper_meta_r;
  logic [UPPER-1:0]     upper_sync_r;
  logic [DEDICATED-1:0] ded_meta_r;
  logic [DEDICATED-1:0] ded_sync_r;
  logic                 wr_en;
  logic                 rd_en;
  logic                 addr_ok;
  logic [15:0]          pin_level_register;
  logic [31:0]          rdata_nxt;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;

  always_comb begin
    unique case (paddr)
      `REG_COMMAND_OFF, `REG_DATA_WRITE_OFF, `REG_OUTPUT_WORD_OFF,
      `REG_PIN_LEVEL_OFF, `REG_MODE_READ_OFF, `REG_BUS_CFG_OFF: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  // two flops before any use; the first stage feeds only the second
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pin_meta_r   <= '0;
      pin_sync_r   <= '0;
      pin_prev_r   <= '0;
      upper_meta_r <= '0;
      upper_sync_r <= '0;
      ded_meta_r   <= '0;
      ded_sync_r   <= '0;
    end else begin
      pin_meta_r   <= pin_in;
      pin_sync_r   <= pin_meta_r;
      pin_prev_r   <= pin_sync_r;
      upper_meta_r <= upper_bus_line_levels;
      upper_sync_r <= upper_meta_r;
      ded_meta_r   <= dedicated_in;
      ded_sync_r   <= ded_meta_r;
    end
  end

  // ------------------------------------------------------------
  // register writes
  // ------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      data_write_low_word_r  <= `MODE_WORD_RESET;
      output_word_register_r <= `OUTPUT_WORD_RESET;
      bus8_mode_r            <= `BUS_CFG_RESET;
    end else if (wr_en) begin
      if (paddr == `REG_DATA_WRITE_OFF)
        data_write_low_word_r <= pwdata[15:0];
      if (paddr == `REG_OUTPUT_WORD_OFF)
        output_word_register_r <= pwdata[15:0];
      if (paddr == `REG_BUS_CFG_OFF)
        bus8_mode_r <= pwdata[0];
    end
  end

  // mode word changes only on the setup command, so a half-written data
  // register never disturbs pins already in use
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pin_mode_word_r <= `MODE_WORD_RESET;
    end else if (wr_en && paddr == `REG_COMMAND_OFF &&
                 pwdata[15:0] == `CMD_PIN_SETUP) begin
      pin_mode_word_r <= data_write_low_word_r;
    end
  end

  // ------------------------------------------------------------
  // pin cells
  // ------------------------------------------------------------
  logic [PINS-1:0] cell_oe;
  logic [PINS-1:0] cell_out;
  logic [7:0]      special_src;

  assign special_src = {sources.compare_result, sources.sync_pulse};

  genvar g;
  generate
    for (g = 0; g < PINS; g++) begin : g_pin
      pin_cell u_cell (
        .clock       (clock),
        .rst         (rst),
        .mode        (pin_mode_word_r[`MODE_BITS_PER_PIN*g +: 2]),
        .gp_out      (output_word_register_r[g]),
        .status_out  (sources.drive_status[g]),
        .special_out (special_src[g]),
        .pin_oe_r    (cell_oe[g]),
        .pin_out_r   (cell_out[g])
      );
    end
  endgenerate

  assign pin_oe  = cell_oe;
  assign pin_out = cell_out;

  // ------------------------------------------------------------
  // input events
  // ------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sync_rise_r       <= '0;
      sync_fall_r       <= '0;
      ext_start_level_r <= '0;
      ext_start_edge_r  <= '0;
      dedicated_level_r <= '0;
    end else begin
      for (int i = 0; i < PINS; i++) begin
        sync_rise_r[i] <= !cell_oe[i] && pin_sync_r[i] && !pin_prev_r[i];
        sync_fall_r[i] <= !cell_oe[i] && !pin_sync_r[i] && pin_prev_r[i];
      end
      for (int j = 0; j < 2; j++) begin
        ext_start_level_r[j] <= !cell_oe[4+j] && pin_sync_r[4+j];
        ext_start_edge_r[j]  <= !cell_oe[4+j] && (pin_sync_r[4+j] ^ pin_prev_r[4+j]);
      end
      // disabled dedicated functions expose the raw level
      dedicated_level_r <= ded_sync_r & ~dedicated_fn_en;
    end
  end

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  // upper byte reads zero on a 16-bit bus: the lines then carry data
  assign pin_level_register = {bus8_mode_r ? upper_sync_r : 8'h00, pin_sync_r};

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    unique case (paddr)
      `REG_PIN_LEVEL_OFF: rdata_nxt = {16'h0000, pin_level_register};
      `REG_MODE_READ_OFF: rdata_nxt = {16'h0000, pin_mode_word_r};
      `REG_BUS_CFG_OFF:   rdata_nxt = {31'h0000_0000, bus8_mode_r};
      default:            rdata_nxt = 32'h0000_0000;
    endcase
  end

  // read data is captured in setup so the access phase answers at once
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      if (rd_en)
        prdata <= rdata_nxt;
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  input_mode_a: assert property (@(posedge clock) disable iff (rst)
    (pin_mode_word_r[1:0] == 2'b00) |=> !pin_oe[0])
    else $error("pin 0 driven in input mode");
  gp_out_a: assert property (@(posedge clock) disable iff (rst)
    (pin_mode_word_r[3:2] == 2'b01) |=>
      (pin_oe[1] && pin_out[1] == $past(output_word_register_r[1])))
    else $error("pin 1 general output wrong");
  status_out_a: assert property (@(posedge clock) disable iff (rst)
    (pin_mode_word_r[5:4] == 2'b10) |=> (pin_out[2] == $past(sources.drive_status[2])))
    else $error("pin 2 status output wrong");
  sync_pulse_a: assert property (@(posedge clock) disable iff (rst)
    (pin_mode_word_r[7:6] == 2'b11) |=> (pin_oe[3] && pin_out[3] == $past(sources.sync_pulse[3])))
    else $error("pin 3 sync pulse wrong");
  compare_out_a: assert property (@(posedge clock) disable iff (rst)
    (pin_mode_word_r[15:14] == 2'b11) |=> (pin_out[7] == $past(sources.compare_result[3])))
    else $error("pin 7 compare output wrong");
  mode_hold_a: assert property (@(posedge clock) disable iff (rst)
    !(wr_en && paddr == `REG_COMMAND_OFF) |=> $stable(pin_mode_word_r))
    else $error("mode word changed without command");
  level_read_a: assert property (@(posedge clock) disable iff (rst)
    (rd_en && paddr == `REG_PIN_LEVEL_OFF) |=> (prdata[7:0] == $past(pin_sync_r)))
    else $error("pin level read wrong");
  upper_read_a: assert property (@(posedge clock) disable iff (rst)
    (rd_en && paddr == `REG_PIN_LEVEL_OFF && bus8_mode_r) |=>
      (prdata[15:8] == $past(upper_sync_r)))
    else $error("upper line read wrong");
  rise_event_a: assert property (@(posedge clock) disable iff (rst)
    (!cell_oe[0] && $rose(pin_sync_r[0])) |=> sync_rise_r[0])
    else $error("rising edge missed");
  rise_seven_a: assert property (@(posedge clock) disable iff (rst)
    (!cell_oe[7] && $rose(pin_sync_r[7])) |=> sync_rise_r[7])
    else $error("pin 7 rising edge missed");
  fall_event_a: assert property (@(posedge clock) disable iff (rst)
    (!cell_oe[1] && $fell(pin_sync_r[1])) |=> sync_fall_r[1])
    else $error("falling edge missed");
  driven_quiet_a: assert property (@(posedge clock) disable iff (rst)
    cell_oe[2] |=> (!sync_rise_r[2] && !sync_fall_r[2]))
    else $error("edge event on a driven pin");

  // ------------------------------------------------------------
  // checks: pin drive by mode pair
  // ------------------------------------------------------------
  input_three_a: assert property (@(posedge clock) disable iff (rst)
    (pin_mode_word_r[7:6] == 2'b00) |=> !pin_oe[3])
    else $error("pin 3 driven in input mode");
  input_seven_a: assert property (@(posedge clock) disable iff (rst)
    (pin_mode_word_r[15:14] == 2'b00) |=> !pin_oe[7])
    else $error("pin 7 driven in input mode");
  pair_layout_a: assert property (@(posedge clock) disable iff (rst)
    pin_oe[5] == $past(|pin_mode_word_r[11:10]))
    else $error("pin 5 direction not from bits 11 and 10");
  gp_five_a: assert property (@(posedge clock) disable iff (rst)
    (pin_mode_word_r[11:10] == 2'b01) |=>
      (pin_oe[5] && pin_out[5] == $past(output_word_register_r[5])))
    else $error("pin 5 general output wrong");
  gp_seven_a: assert property (@(posedge clock) disable iff (rst)
    (pin_mode_word_r[15:14] == 2'b01) |=>
      (pin_oe[7] && pin_out[7] == $past(output_word_register_r[7])))
    else $error("pin 7 general output wrong");
  status_one_a: assert property (@(posedge clock) disable iff (rst)
    (pin_mode_word_r[3:2] == 2'b10) |=>
      (pin_oe[1] && pin_out[1] == $past(sources.drive_status[1])))
    else $error("pin 1 status output wrong");
  status_six_a: assert property (@(posedge clock) disable iff (rst)
    (pin_mode_word_r[13:12] == 2'b10) |=>
      (pin_oe[6] && pin_out[6] == $past(sources.drive_status[6])))
    else $error("pin 6 status output wrong");
  pulse_zero_a: assert property (@(posedge clock) disable iff (rst)
    (pin_mode_word_r[1:0] == 2'b11) |=>
      (pin_oe[0] && pin_out[0] == $past(sources.sync_pulse[0])))
    else $error("pin 0 sync pulse wrong");
  pulse_one_a: assert property (@(posedge clock) disable iff (rst)
    (pin_mode_word_r[3:2] == 2'b11) |=>
      (pin_oe[1] && pin_out[1] == $past(sources.sync_pulse[1])))
    else $error("pin 1 sync pulse wrong");
  special_four_a: assert property (@(posedge clock) disable iff (rst)
    (pin_mode_word_r[9:8] == 2'b11) |=>
      (pin_oe[4] && pin_out[4] == $past(sources.compare_result[0])))
    else $error("pin 4 compare output wrong");
  compare_five_a: assert property (@(posedge clock) disable iff (rst)
    (pin_mode_word_r[11:10] == 2'b11) |=>
      (pin_oe[5] && pin_out[5] == $past(sources.compare_result[1])))
    else $error("pin 5 compare output wrong");
  compare_six_a: assert property (@(posedge clock) disable iff (rst)
    (pin_mode_word_r[13:12] == 2'b11) |=>
      (pin_oe[6] && pin_out[6] == $past(sources.compare_result[2])))
    else $error("pin 6 compare output wrong");

  // ------------------------------------------------------------
  // checks: external start, dedicated inputs, register path
  // ------------------------------------------------------------
  // start events come only from released pins, so a driven pin never starts motion
  ext_level_a: assert property (@(posedge clock) disable iff (rst)
    !cell_oe[4] |=> (ext_start_level_r[0] == $past(pin_sync_r[4])))
    else $error("pin 4 start level wrong");
  ext_edge_a: assert property (@(posedge clock) disable iff (rst)
    (!cell_oe[5] && $changed(pin_sync_r[5])) |=> ext_start_edge_r[1])
    else $error("pin 5 start edge missed");
  ext_driven_a: assert property (@(posedge clock) disable iff (rst)
    cell_oe[4] |=> (!ext_start_level_r[0] && !ext_start_edge_r[0]))
    else $error("start event from a driven pin");
  ded_used_a: assert property (@(posedge clock) disable iff (rst)
    dedicated_fn_en[0] |=> !dedicated_level_r[0])
    else $error("dedicated input shown while in use");
  ded_free_a: assert property (@(posedge clock) disable iff (rst)
    !dedicated_fn_en[8] |=> (dedicated_level_r[8] == $past(ded_sync_r[8])))
    else $error("free dedicated input level wrong");
  upper_blank_a: assert property (@(posedge clock) disable iff (rst)
    (rd_en && paddr == `REG_PIN_LEVEL_OFF && !bus8_mode_r) |=> (prdata[15:8] == 8'h00))
    else $error("upper lines shown on a 16-bit bus");
  data_write_a: assert property (@(posedge clock) disable iff (rst)
    (wr_en && paddr == `REG_DATA_WRITE_OFF) |=> (data_write_low_word_r == $past(pwdata[15:0])))
    else $error("data write register not loaded");
  mode_load_a: assert property (@(posedge clock) disable iff (rst)
    (wr_en && paddr == `REG_COMMAND_OFF && pwdata[15:0] == `CMD_PIN_SETUP) |=>
      (pin_mode_word_r == $past(data_write_low_word_r)))
    else $error("setup command did not load the mode word");
  word_write_a: assert property (@(posedge clock) disable iff (rst)
    (wr_en && paddr == `REG_OUTPUT_WORD_OFF) |=>
      (output_word_register_r == $past(pwdata[15:0])))
    else $error("output word not loaded");
  mode_read_a: assert property (@(posedge clock) disable iff (rst)
    (rd_en && paddr == `REG_MODE_READ_OFF) |=> (prdata == {16'h0000, $past(pin_mode_word_r)}))
    else $error("mode word read back wrong");
endmodule // multi_purpose_pin_port
`default_nettype wire

/* File: hdl/mpp_cfg.svh */
// constants for the multi-purpose pin port: register offsets, field layout, reset values
// assumes a 32-bit apb slave with word-aligned registers
`ifndef MPP_CFG_SVH
`define MPP_CFG_SVH
`define REG_COMMAND_OFF     12'h000
`define REG_DATA_WRITE_OFF  12'h004
`define REG_OUTPUT_WORD_OFF 12'h008
`define REG_PIN_LEVEL_OFF   12'h00C
`define REG_MODE_READ_OFF   12'h010
`define REG_BUS_CFG_OFF     12'h014
`define CMD_PIN_SETUP       16'h0021
`define MODE_WORD_RESET     16'h0000
`define OUTPUT_WORD_RESET   16'h0000
`define BUS_CFG_RESET       1'b0
`define MODE_BITS_PER_PIN   2
`endif

/* File: hdl/mpp_pkg.sv */
// types shared by the multi-purpose pin port
// assumes mpp_cfg.svh supplies the numeric constants
package mpp_pkg;
  typedef enum logic [1:0] {
    PIN_FN_INPUT  = 2'b00,
    PIN_FN_OUTPUT = 2'b01,
    PIN_FN_STATUS = 2'b10,
    PIN_FN_SPECIAL = 2'b11
  } pin_fn_t;

  typedef struct packed {
    logic [7:0] oe;
    logic [7:0] out;
  } pin_drive_t;

  typedef struct packed {
    logic [3:0] sync_pulse;
    logic [3:0] compare_result;
    logic [7:0] drive_status;
  } pin_sources_t;
endpackage

/* File: hdl/pin_cell.sv */
// one multi-purpose pin: selects direction and output source from its mode pair
// assumes sources arrive on the same clock
`timescale 1ns/1ns
`default_nettype none
module pin_cell
  import mpp_pkg::*;
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // selection
  input  wire logic [1:0] mode,
  // sources
  input  wire logic       gp_out,
  input  wire logic       status_out,
  input  wire logic       special_out,
  // pin drive
  output logic            pin_oe_r,
  output logic            pin_out_r
);
  pin_fn_t fn;
  assign fn = pin_fn_t'(mode);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pin_oe_r  <= 1'b0;
      pin_out_r <= 1'b0;
    end else begin
      unique case (fn)
        PIN_FN_INPUT: begin
          pin_oe_r  <= 1'b0;
          pin_out_r <= 1'b0;
        end
        PIN_FN_OUTPUT: begin
          pin_oe_r  <= 1'b1;
          pin_out_r <= gp_out;
        end
        PIN_FN_STATUS: begin
          pin_oe_r  <= 1'b1;
          pin_out_r <= status_out;
        end
        PIN_FN_SPECIAL: begin
          pin_oe_r  <= 1'b1;
          pin_out_r <= special_out;
        end
      endcase
    end
  end
endmodule // pin_cell
`default_nettype wire

/* File: verif/pin_partner.sv */
// far side of the pin port: external switches and drivers on the eight pins
// assumes pin_oe high means the port drives the pin
`timescale 1ns/1ns
`default_nettype none
module pin_partner (
  // port side
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  // external drivers, used only where the port releases a pin
  input  wire logic [7:0] ext_level,
  // wire level fed back to the port
  output logic      [7:0] pin_in
);
  // a driven pin reads back its own level, so outputs show in the level register
  assign pin_in = (pin_out & pin_oe) | (ext_level & ~pin_oe);
endmodule // pin_partner
`default_nettype wire

/* File: verif/tb_multi_purpose_pin_port.sv */
// self-checking bench for the multi-purpose pin port
// assumes an apb slave that answers in its own time and pin_partner closing the pin loop
`timescale 1ns/1ns
`default_nettype none
`include "mpp_cfg.svh"
module tb_multi_purpose_pin_port
  import mpp_pkg::*;
;
  logic         clock, rst, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata, rd;
  logic [7:0]   pin_in, pin_out, pin_oe, ext_lvl, upper, r, f;
  logic [8:0]   ded_in, ded_en, ded_lvl;
  logic [1:0]   st_lvl, st_edge, e;
  pin_sources_t src;
  pin_drive_t   x;
  logic [15:0]  m;
  logic [7:0]   rise, fall;
  int           n_fail, n_compared;

  multi_purpose_pin_port dut (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .upper_bus_line_levels(upper), .dedicated_in(ded_in), .dedicated_fn_en(ded_en),
    .sources(src), .sync_rise_r(rise), .sync_fall_r(fall), .ext_start_level_r(st_lvl),
    .ext_start_edge_r(st_edge), .dedicated_level_r(ded_lvl));
  pin_partner u_far (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_lvl), .pin_in(pin_in));

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // request held from setup until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // only the watchdog ends a wait that never sees pready
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(what, exp, rd);
  endtask

  task automatic set_mode(input logic [15:0] w);
    apb(1'b1, `REG_DATA_WRITE_OFF, {16'h0000, w});
    apb(1'b1, `REG_COMMAND_OFF, {16'h0000, `CMD_PIN_SETUP});
    repeat (3) @(posedge clock);
  endtask

  // watch edge outputs over a bounded span after moving the external levels
  task automatic edges(input logic [7:0] lv);
    r = 8'h00;
    f = 8'h00;
    e = 2'b00;
    ext_lvl <= lv;
    repeat (6) begin
      @(posedge clock);
      r |= rise;
      f |= fall;
      e |= st_edge;
    end
  endtask

  task automatic done(input string name);
    $display("test %s ends: %0d compared, %0d failed", name, n_compared, n_fail);
  endtask

  task automatic tally_and_finish;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  function automatic pin_drive_t exp_drive(input logic [15:0] w, input logic [7:0] ow);
    pin_drive_t d;
    d = '0;
    for (int n = 0; n < 8; n++) begin
      d.oe[n] = |w[2*n +: 2];
      case (w[2*n +: 2])
        2'b01: d.out[n] = ow[n];
        2'b10: d.out[n] = src.drive_status[n];
        2'b11: d.out[n] = (n < 4) ? src.sync_pulse[n] : src.compare_result[n-4];
        default: d.out[n] = 1'b0;
      endcase
    end
    return d;
  endfunction

  initial begin
    repeat (3000) @(posedge clock);
    n_fail++;
    tally_and_finish;
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {ext_lvl, upper, ded_in, ded_en} = '0;
    src = '0;
    n_fail = 0;
    n_compared = 0;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    chk("oe at reset", 32'h0, {24'h0, pin_oe});
    rdchk("mode at reset", `REG_MODE_READ_OFF, 32'h0);
    ext_lvl <= 8'h3C;
    for (int i = 0; i < 2; i++) begin
      m = i ? 16'hD8D8 : 16'h2727;
      src <= i ? 16'hA5F0 : 16'h5A0F;
      apb(1'b1, `REG_OUTPUT_WORD_OFF, i ? 32'h0000_005A : 32'h0000_00A5);
      set_mode(m);
      x = exp_drive(m, i ? 8'h5A : 8'hA5);
      chk("pin oe", {24'h0, x.oe}, {24'h0, pin_oe});
      chk("pin out", {24'h0, x.out}, {24'h0, pin_out & pin_oe});
      rdchk("mode read", `REG_MODE_READ_OFF, {16'h0, m});
      rdchk("level", `REG_PIN_LEVEL_OFF, {24'h0, x.out | (8'h3C & ~x.oe)});
    end
    apb(1'b1, `REG_DATA_WRITE_OFF, 32'h0000_0000);
    repeat (3) @(posedge clock);
    chk("oe held", {24'h0, x.oe}, {24'h0, pin_oe});
    done("modes");
    set_mode(16'h0000);
    chk("all input", 32'h0, {24'h0, pin_oe});
    edges(8'h00);
    edges(8'hFF);
    chk("rise", 32'hFF, {24'h0, r});
    chk("start edge", 32'h3, {30'h0, e});
    chk("start level", 32'h3, {30'h0, st_lvl});
    edges(8'h00);
    chk("fall", 32'hFF, {24'h0, f});
    chk("start fall", 32'h3, {30'h0, e});
    done("edges");
    upper <= 8'hC3;
    apb(1'b1, `REG_BUS_CFG_OFF, 32'h0000_0001);
    repeat (3) @(posedge clock);
    rdchk("upper on", `REG_PIN_LEVEL_OFF, 32'h0000_C300);
    apb(1'b1, `REG_BUS_CFG_OFF, 32'h0000_0000);
    rdchk("upper off", `REG_PIN_LEVEL_OFF, 32'h0000_0000);
    ded_in <= 9'h1A5;
    ded_en <= 9'h00F;
    repeat (4) @(posedge clock);
    chk("dedicated", 32'h1A0, {23'h0, ded_lvl});
    apb(1'b1, 12'h0F0, 32'h0000_FFFF);
    chk("bad write err", 32'h1, {31'h0, err});
    rdchk("bad read", 12'h0FC, 32'h0);
    chk("bad read err", 32'h1, {31'h0, err});
    done("misc");
    tally_and_finish;
  end
endmodule // tb_multi_purpose_pin_port
`default_nettype wire
